// ---- uss_pkg.sv ----
`default_nettype none
package uss_pkg;
	// register addresses on the local register port
	localparam logic [2:0] ADR_RX_CTRL  = 3'h0;
	localparam logic [2:0] ADR_TX_HOLD  = 3'h1;
	localparam logic [2:0] ADR_TX_CTRL  = 3'h2;
	localparam logic [2:0] ADR_BAUD_DIV = 3'h3;
	localparam logic [2:0] ADR_RX_HOLD  = 3'h4;
	localparam logic [2:0] ADR_INT_STAT = 3'h5;
	localparam logic [2:0] ADR_INT_MASK = 3'h6;
	localparam logic [2:0] ADR_INT_CTRL = 3'h7;
	// transmit_status_control bits
	localparam int TXC_CLK_SRC  = 7;
	localparam int TXC_NINE     = 6;
	localparam int TXC_TX_EN    = 5;
	localparam int TXC_SYNC     = 4;
	localparam int TXC_SR_EMPTY = 1;
	localparam int TXC_NINTH    = 0;
	localparam logic [7:0] TXC_WR_MASK = 8'hf5;
	// receive_status_control bits
	localparam int RXC_PORT_EN   = 7;
	localparam int RXC_NINE      = 6;
	localparam int RXC_CONT      = 4;
	localparam int RXC_FRAME_ERR = 2;
	localparam int RXC_OVERRUN   = 1;
	localparam int RXC_NINTH     = 0;
	localparam logic [7:0] RXC_WR_MASK = 8'hf8;
	// interrupt status / mask bits, interrupt control bits
	localparam int INT_TX      = 0;
	localparam int INT_RX      = 1;
	localparam int INTC_GLOBAL = 7;
	localparam int INTC_PERIPH = 6;
	// values after reset
	localparam logic [7:0] TX_CTRL_RST = 8'h02;
	localparam logic [7:0] RX_CTRL_RST = 8'h00;
	localparam logic [7:0] TX_HOLD_RST = 8'h00;
	localparam logic [7:0] RX_HOLD_RST = 8'h00;
	localparam logic [7:0] BAUD_RST    = 8'h00;
	// frame lengths
	localparam logic [3:0] BITS_8 = 4'h8;
	localparam logic [3:0] BITS_9 = 4'h9;
	// timing
	localparam int CLK_PERIOD_NS  = 25;
	localparam int LINK_PERIOD_NS = 200;
	localparam int LINK_HALF_CYC  = LINK_PERIOD_NS / (2 * CLK_PERIOD_NS);
	localparam logic [7:0] LINK_HALF = 8'(LINK_HALF_CYC);
endpackage
`default_nettype wire

// ---- uss_link_if.sv ----
`timescale 1ns/1ps
`default_nettype none
interface uss_link_if;
	logic ck;
	logic dt_dev_o;
	logic dt_dev_oe;
	logic dt_mst_o;
	logic dt_mst_oe;
	logic dt;
	// pulled-up data wire
	assign dt = dt_dev_oe ? dt_dev_o : (dt_mst_oe ? dt_mst_o : 1'b1);
	modport dev (input ck, input dt, output dt_dev_o, output dt_dev_oe);
	modport mst (output ck, input dt, output dt_mst_o, output dt_mst_oe);
endinterface
`default_nettype wire

// ---- uss_slave_dev.sv ----
// Our own choices: the plain strobed port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module uss_slave_dev
	import uss_pkg::*;
(
	// clock and reset
	input  wire logic       clk,
	input  wire logic       reset,
	// register port
	input  wire logic [2:0] addr,
	input  wire logic [7:0] wdata,
	input  wire logic       wr,
	input  wire logic       rd,
	output var  logic [7:0] rdata,
	// core
	input  wire logic       core_sleep,
	output var  logic       irq,
	output var  logic       vector_req,
	// link
	uss_link_if.dev         link
);
	import uss_pkg::*;

	typedef struct packed {
		logic       ck_s1;
		logic       ck_s2;
		logic       ck_prev;
		logic       dt_s1;
		logic       dt_s2;
		logic [7:0] tx_ctrl;
		logic [7:0] rx_ctrl;
		logic [7:0] baud;
		logic [7:0] tx_hold;
		logic       tx_full;
		logic [8:0] tx_shift;
		logic       tx_busy;
		logic [3:0] tx_cnt;
		logic [3:0] tx_len;
		logic [8:0] rx_shift;
		logic [3:0] rx_cnt;
		logic [7:0] rx_hold;
		logic       rx_ninth;
		logic       rx_full;
		logic       overrun;
		logic [1:0] int_stat;
		logic [1:0] int_mask;
		logic [1:0] int_ctrl;
		logic [7:0] rdata;
		logic       irq;
		logic       vec;
		logic       dt_o;
		logic       dt_oe;
	} uss_dev_t;

	uss_dev_t s;
	uss_dev_t next_s;

	function automatic logic [3:0] frame_len(input logic nine);
		frame_len = nine ? BITS_9 : BITS_8;
	endfunction

	logic       active;
	logic       fall;
	logic       tx_on;
	logic       rx_on;
	logic       tx_end;
	logic [8:0] rx_word;
	logic [1:0] int_set;

	always_comb
	begin
		next_s = s;
		int_set = 2'h0;
		rx_word = s.rx_shift;
		// second stage only feeds logic
		next_s.ck_s1 = link.ck;
		next_s.ck_s2 = s.ck_s1;
		next_s.ck_prev = s.ck_s2;
		next_s.dt_s1 = link.dt;
		next_s.dt_s2 = s.dt_s1;
		fall = s.ck_prev & ~s.ck_s2;
		// slave only with external clock selected
		active = s.tx_ctrl[TXC_SYNC] & s.rx_ctrl[RXC_PORT_EN]
			& ~s.tx_ctrl[TXC_CLK_SRC];
		tx_on = active & s.tx_ctrl[TXC_TX_EN];
		// single receive bit plays no part here
		rx_on = active & s.rx_ctrl[RXC_CONT] & ~tx_on;
		tx_end = 1'b0;

		// transmit shifter: advance on each master falling edge
		if (s.tx_busy && fall)
		begin
			next_s.tx_shift = {1'b0, s.tx_shift[8:1]};
			next_s.tx_cnt = s.tx_cnt + 4'h1;
			if (s.tx_cnt + 4'h1 == s.tx_len)
			begin
				next_s.tx_busy = 1'b0;
				tx_end = 1'b1;
			end
		end
		if (!tx_on)
			next_s.tx_busy = 1'b0;
		// hand-off from holding buffer, also while core sleeps
		if (tx_on && s.tx_full && (!s.tx_busy || tx_end))
		begin
			next_s.tx_shift = {s.tx_ctrl[TXC_NINTH], s.tx_hold};
			next_s.tx_len = frame_len(s.tx_ctrl[TXC_NINE]);
			next_s.tx_cnt = 4'h0;
			next_s.tx_busy = 1'b1;
			next_s.tx_full = 1'b0;
			int_set[INT_TX] = 1'b1;
		end
		next_s.dt_o = next_s.tx_shift[0];
		next_s.dt_oe = next_s.tx_busy;

		// receiver: sample on master falling edge
		if (!s.rx_ctrl[RXC_CONT])
		begin
			next_s.overrun = 1'b0;
			next_s.rx_cnt = 4'h0;
		end
		else if (rx_on && fall && !s.overrun)
		begin
			rx_word[s.rx_cnt] = s.dt_s2;
			next_s.rx_shift = rx_word;
			next_s.rx_cnt = s.rx_cnt + 4'h1;
			if (s.rx_cnt + 4'h1 == frame_len(s.rx_ctrl[RXC_NINE]))
			begin
				next_s.rx_cnt = 4'h0;
				if (s.rx_full)
					next_s.overrun = 1'b1;
				else
				begin
					// works whether or not the core sleeps
					next_s.rx_hold = rx_word[7:0];
					next_s.rx_ninth = rx_word[8];
					next_s.rx_full = 1'b1;
					int_set[INT_RX] = 1'b1;
				end
			end
		end

		// register port
		next_s.rdata = 8'h00;
		if (rd)
		begin
			case (addr)
				ADR_RX_CTRL:
				begin
					next_s.rdata = s.rx_ctrl;
					next_s.rdata[RXC_FRAME_ERR] = 1'b0;
					next_s.rdata[RXC_OVERRUN] = s.overrun;
					next_s.rdata[RXC_NINTH] = s.rx_ninth;
				end
				ADR_TX_CTRL:
				begin
					next_s.rdata = s.tx_ctrl;
					next_s.rdata[TXC_SR_EMPTY] = ~s.tx_busy;
				end
				ADR_BAUD_DIV: next_s.rdata = s.baud;
				ADR_RX_HOLD:
				begin
					next_s.rdata = s.rx_hold;
					// a word landing now keeps the buffer full
					next_s.rx_full = int_set[INT_RX];
				end
				ADR_INT_STAT: next_s.rdata = {6'h00, s.int_stat};
				ADR_INT_MASK: next_s.rdata = {6'h00, s.int_mask};
				ADR_INT_CTRL: next_s.rdata = {s.int_ctrl, 6'h00};
				default: next_s.rdata = 8'h00;
			endcase
		end
		if (wr)
		begin
			case (addr)
				ADR_RX_CTRL: next_s.rx_ctrl = wdata & RXC_WR_MASK;
				ADR_TX_HOLD:
				begin
					next_s.tx_hold = wdata;
					next_s.tx_full = 1'b1;
					next_s.int_stat[INT_TX] = 1'b0;
				end
				ADR_TX_CTRL: next_s.tx_ctrl = wdata & TXC_WR_MASK;
				ADR_BAUD_DIV: next_s.baud = wdata;
				ADR_INT_STAT: next_s.int_stat = s.int_stat & ~wdata[1:0];
				ADR_INT_MASK: next_s.int_mask = wdata[1:0];
				ADR_INT_CTRL: next_s.int_ctrl = wdata[7:6];
				default: next_s.int_mask = s.int_mask;
			endcase
		end
		// events win over a clear in the same cycle
		next_s.int_stat = next_s.int_stat | int_set;
		// level wake-up, vector only with both enables
		next_s.irq = |(next_s.int_stat & next_s.int_mask);
		next_s.vec = next_s.irq & next_s.int_ctrl[1]
			& next_s.int_ctrl[0];
	end

	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			s <= '0;
			s.tx_ctrl <= TX_CTRL_RST;
			s.rx_ctrl <= RX_CTRL_RST;
			s.baud <= BAUD_RST;
			s.tx_hold <= TX_HOLD_RST;
			s.rx_hold <= RX_HOLD_RST;
			s.tx_len <= BITS_8;
			s.dt_s1 <= 1'b1;
			s.dt_s2 <= 1'b1;
		end
		else
			s <= next_s;
	end

	assign rdata = s.rdata;
	assign irq = s.irq;
	assign vector_req = s.vec;
	assign link.dt_dev_o = s.dt_o;
	assign link.dt_dev_oe = s.dt_oe;

	// core_sleep changes nothing: the link clock is external
	logic unused_sleep;
	assign unused_sleep = core_sleep;
endmodule // uss_slave_dev
`default_nettype wire

// ---- uss_link_master.sv ----
`timescale 1ns/1ps
`default_nettype none
module uss_link_master
	import uss_pkg::*;
(
	// clock and reset
	input  wire logic       clk,
	input  wire logic       reset,
	// user side
	input  wire logic       start,
	input  wire logic       send,
	input  wire logic       nine,
	input  wire logic [8:0] wdata,
	output var  logic       busy,
	output var  logic       done,
	output var  logic [8:0] rdata,
	// link
	uss_link_if.mst         link
);
	import uss_pkg::*;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_LOW  = 2'b01,
		ST_HIGH = 2'b10,
		ST_TAIL = 2'b11
	} uss_mst_state_t;

	typedef struct packed {
		uss_mst_state_t st;
		logic           dt_s1;
		logic           dt_s2;
		logic [7:0]     tmr;
		logic [3:0]     cnt;
		logic [3:0]     len;
		logic           send;
		logic [8:0]     shift;
		logic           ck;
		logic           dt_o;
		logic           dt_oe;
		logic           busy;
		logic           done;
		logic [8:0]     rdata;
	} uss_mst_t;

	uss_mst_t s;
	uss_mst_t next_s;

	always_comb
	begin
		next_s = s;
		next_s.dt_s1 = link.dt;
		next_s.dt_s2 = s.dt_s1;
		next_s.done = 1'b0;
		next_s.tmr = (s.tmr == 8'h00) ? 8'h00 : s.tmr - 8'h01;
		case (s.st)
			ST_IDLE:
			begin
				next_s.ck = 1'b0;
				if (start)
				begin
					next_s.st = ST_LOW;
					next_s.tmr = LINK_HALF - 8'h01;
					next_s.cnt = 4'h0;
					next_s.len = nine ? BITS_9 : BITS_8;
					next_s.send = send;
					next_s.shift = wdata;
					next_s.dt_o = wdata[0];
					next_s.dt_oe = send;
					next_s.busy = 1'b1;
				end
			end
			ST_LOW:
				if (s.tmr == 8'h00)
				begin
					next_s.st = ST_HIGH;
					next_s.ck = 1'b1;
					next_s.dt_o = s.shift[0];
					next_s.tmr = LINK_HALF - 8'h01;
				end
			ST_HIGH:
				if (s.tmr == 8'h00)
				begin
					// falling edge: master takes the bit now, the device three cycles later
					next_s.ck = 1'b0;
					next_s.tmr = LINK_HALF - 8'h01;
					next_s.shift = {1'b0, s.shift[8:1]};
					next_s.rdata[s.cnt] = s.dt_s2;
					next_s.cnt = s.cnt + 4'h1;
					next_s.st = ST_LOW;
					if (s.cnt + 4'h1 == s.len)
					begin
						// last bit stays driven while far end syncs it
						next_s.st = ST_TAIL;
						if (!s.send)
							next_s.rdata[8] = (s.len == BITS_9) & s.dt_s2;
					end
				end
			ST_TAIL:
				if (s.tmr == 8'h00)
				begin
					next_s.st = ST_IDLE;
					next_s.dt_oe = 1'b0;
					next_s.busy = 1'b0;
					next_s.done = 1'b1;
				end
			default: next_s.st = ST_IDLE;
		endcase
	end

	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			s <= '0;
			s.st <= ST_IDLE;
			s.dt_s1 <= 1'b1;
			s.dt_s2 <= 1'b1;
		end
		else
			s <= next_s;
	end

	assign busy = s.busy;
	assign done = s.done;
	assign rdata = s.rdata;
	assign link.ck = s.ck;
	assign link.dt_mst_o = s.dt_o;
	assign link.dt_mst_oe = s.dt_oe;
endmodule // uss_link_master
`default_nettype wire

// ---- uss_link_checker.sv ----
`timescale 1ns/1ps
`default_nettype none
module uss_link_checker (
	// clock and reset
	input wire logic clk,
	input wire logic reset,
	// link
	input wire logic ck,
	input wire logic dt_dev_o,
	input wire logic dt_dev_oe,
	input wire logic dt_mst_o,
	input wire logic dt_mst_oe
);
	logic [3:0] since_fall;
	default clocking @(posedge clk); endclocking
	default disable iff (reset);
	// cycles since the shift clock last fell
	always_ff @(posedge clk or posedge reset)
		if (reset)
			since_fall <= 4'h0;
		else if ($fell(ck))
			since_fall <= 4'h1;
		else if (since_fall != 4'hf)
			since_fall <= since_fall + 4'h1;
	a_no_contention: assert property (!(dt_dev_oe && dt_mst_oe))
		else $error("both ends drive data");
	a_dev_after_fall: assert property (
		(dt_dev_oe && $past(dt_dev_oe) && $changed(dt_dev_o))
		|-> since_fall inside {[2:6]}) else $error("device bit moved late");
	a_dev_hold_high: assert property (
		(ck && $past(ck) && dt_dev_oe && $past(dt_dev_oe))
		|-> $stable(dt_dev_o)) else $error("device bit moved while high");
	a_mst_hold_high: assert property (
		(ck && $past(ck) && dt_mst_oe && $past(dt_mst_oe))
		|-> $stable(dt_mst_o)) else $error("master bit moved while high");
	a_ck_high_min: assert property ($rose(ck) |-> ck[*4])
		else $error("clock high too short");
	a_ck_low_min: assert property ($fell(ck) |-> !ck[*4])
		else $error("clock low too short");
	a_reset_idle: assert property (
		$past(reset) |-> !(ck || dt_dev_oe || dt_mst_oe))
		else $error("link busy after reset");
	a_oe_drop: assert property (
		$fell(dt_dev_oe) |-> since_fall inside {[2:6]})
		else $error("device released data off time");
endmodule // uss_link_checker
`default_nettype wire

// ---- usart_sync_slave_mode_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module usart_sync_slave_mode_tb;
	import uss_pkg::*;
	logic       clk, reset, wr, rd, core_sleep, irq, vector_req;
	logic       start, send, nine, busy, done;
	logic [2:0] addr;
	logic [7:0] wdata, rdata;
	logic [8:0] m_wdata, m_rdata;
	int         mismatches, checks;
	uss_link_if uss_link_if_i ();
	uss_slave_dev uss_slave_dev_i (.clk(clk), .reset(reset), .addr(addr),
		.wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
		.core_sleep(core_sleep), .irq(irq), .vector_req(vector_req),
		.link(uss_link_if_i));
	uss_link_master uss_link_master_i (.clk(clk), .reset(reset),
		.start(start), .send(send), .nine(nine), .wdata(m_wdata),
		.busy(busy), .done(done), .rdata(m_rdata), .link(uss_link_if_i));
	uss_link_checker uss_link_checker_i (.clk(clk), .reset(reset),
		.ck(uss_link_if_i.ck), .dt_dev_o(uss_link_if_i.dt_dev_o),
		.dt_dev_oe(uss_link_if_i.dt_dev_oe),
		.dt_mst_o(uss_link_if_i.dt_mst_o),
		.dt_mst_oe(uss_link_if_i.dt_mst_oe));
	initial
	begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	task print_verdict;
		$display("checks %0d mismatches %0d", checks, mismatches);
		if (mismatches == 0 && checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	task chk(input string n, input logic [8:0] e, input logic [8:0] g);
		checks++;
		if (g !== e)
		begin
			mismatches++;
			$display("MISMATCH %s expected %h seen %h", n, e, g);
		end
	endtask
	task wreg(input logic [2:0] a, input logic [7:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
		#1;
	endtask
	task rreg(input logic [2:0] a, input logic [7:0] e, input string n);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1;
		chk(n, {1'b0, e}, {1'b0, rdata});
	endtask
	// one frame clocked by the master, then time for the device to store
	task xfer(input logic s, input logic n, input logic [8:0] d);
		int i;
		@(posedge clk);
		send <= s;
		nine <= n;
		m_wdata <= d;
		start <= 1'b1;
		@(posedge clk);
		start <= 1'b0;
		i = 0;
		while (done !== 1'b1 && i < 300)
		begin
			@(posedge clk);
			#1;
			i++;
		end
		if (done !== 1'b1)
		begin
			mismatches++;
			$display("MISMATCH xfer_done expected 1 seen 0");
			print_verdict;
		end
		repeat (4) @(posedge clk);
	endtask
	initial
	begin
		{reset, wr, rd, addr, wdata, core_sleep} = {1'b1, 14'h0};
		{start, send, nine, m_wdata, mismatches, checks} = '0;
		repeat (20) @(posedge clk);
		reset <= 1'b0;
		rreg(ADR_TX_CTRL, TX_CTRL_RST, "tx_ctrl");
		rreg(ADR_RX_CTRL, RX_CTRL_RST, "rx_ctrl");
		rreg(ADR_RX_HOLD, RX_HOLD_RST, "rx_hold");
		rreg(ADR_TX_HOLD, TX_HOLD_RST, "tx_hold");
		wreg(ADR_BAUD_DIV, 8'h5a);
		rreg(ADR_BAUD_DIV, 8'h5a, "baud");
		$display("test registers done");
		wreg(ADR_TX_CTRL, 8'h10);
		wreg(ADR_RX_CTRL, 8'ha0);
		xfer(1'b1, 1'b0, 9'h03c);
		rreg(ADR_INT_STAT, 8'h00, "single_rx");
		@(posedge clk) core_sleep <= 1'b1;
		wreg(ADR_RX_CTRL, 8'h90);
		xfer(1'b1, 1'b0, 9'h0a5);
		rreg(ADR_INT_STAT, 8'h02, "rx_flag");
		chk("irq_masked", 9'h000, {8'h00, irq});
		wreg(ADR_INT_MASK, 8'h03);
		wreg(ADR_INT_CTRL, 8'hc0);
		rreg(ADR_RX_HOLD, 8'ha5, "rx_word");
		chk("irq", 9'h001, {8'h00, irq});
		chk("vector", 9'h001, {8'h00, vector_req});
		wreg(ADR_INT_STAT, 8'h02);
		chk("irq_clr", 9'h000, {8'h00, irq});
		xfer(1'b1, 1'b0, 9'h011);
		xfer(1'b1, 1'b0, 9'h022);
		rreg(ADR_RX_CTRL, 8'h92, "overrun");
		rreg(ADR_RX_HOLD, 8'h11, "rx_kept");
		wreg(ADR_RX_CTRL, 8'h80);
		rreg(ADR_RX_CTRL, 8'h80, "overrun_clr");
		wreg(ADR_RX_CTRL, 8'hd0);
		xfer(1'b1, 1'b1, 9'h1c3);
		rreg(ADR_RX_CTRL, 8'hd1, "rx_ninth");
		rreg(ADR_RX_HOLD, 8'hc3, "rx_word9");
		$display("test receive done");
		wreg(ADR_RX_CTRL, 8'h80);
		wreg(ADR_INT_STAT, 8'h03);
		wreg(ADR_TX_CTRL, 8'h30);
		wreg(ADR_TX_HOLD, 8'h96);
		repeat (2) @(posedge clk);
		wreg(ADR_TX_HOLD, 8'h4b);
		rreg(ADR_INT_STAT, 8'h00, "tx_flag_held");
		xfer(1'b0, 1'b0, 9'h000);
		chk("tx_word1", 9'h096, m_rdata);
		rreg(ADR_INT_STAT, 8'h01, "tx_flag_set");
		chk("irq_tx", 9'h001, {8'h00, irq});
		chk("vector_tx", 9'h001, {8'h00, vector_req});
		xfer(1'b0, 1'b0, 9'h000);
		chk("tx_word2", 9'h04b, m_rdata);
		@(posedge clk) core_sleep <= 1'b0;
		wreg(ADR_INT_STAT, 8'h01);
		wreg(ADR_TX_CTRL, 8'h71);
		wreg(ADR_TX_HOLD, 8'h5e);
		rreg(ADR_INT_STAT, 8'h01, "tx_flag_awake");
		xfer(1'b0, 1'b1, 9'h000);
		chk("tx_word9", 9'h15e, m_rdata);
		chk("busy", 9'h000, {8'h00, busy});
		rreg(ADR_TX_CTRL, 8'h73, "tx_idle");
		$display("test transmit done");
		print_verdict;
	end
endmodule // usart_sync_slave_mode_tb
`default_nettype wire
